//--- hw/ssdiag_core.sv
/*
  ssdiag_core: status and fault logic of a safety sensor: safety output pair,
  diagnostic output, LED patterns and serial response byte.
  Assumes all sensing inputs come from asynchronous sensor front ends and are
  synchronised here; the serial framing lives outside and exchanges bytes.
*/
// Operation
// RULE1: internal error disables outputs, diag low, red flashes; clear on fix and guard cycle.
// RULE2: error warning: diag low, red flashes, safety outputs stay on.
// RULE3: warning clears by itself once its cause is gone.
// RULE4: warning held 30 minutes also switches safety outputs off.
// RULE5: actuator present, no fault: yellow only, diag and safety outputs high.
// RULE6: marginal zone: yellow flashes 1 Hz, diag pulsed, outputs high.
// RULE7: teaching: red steady, yellow flashes, green off, all outputs low.
// RULE8: tamper interval: green flashes only, outputs low for 10 minutes.
// RULE9: input missing, no actuator: green flashes 1 Hz, all outputs low.
// RULE10: input missing, actuator present: green flash, yellow, diag high, outputs low.
// RULE11: serial variant swaps diag output for serial in and out.
// RULE12: chain holds at most 31 sensors.
// RULE13: response byte is supplied continuously without request.
// RULE14: controller supplies one request byte per sensor.
// RULE15: gateway link failure keeps safety outputs in present state.
// RULE16: response bits 0,1,4,5: outputs on, actuator, inputs live, hysteresis.
// RULE17: response bit 6 warning pending, bit 7 error with outputs off.
// RULE18: serial error clears when cause gone and request bit7 falls or guard opens.
// RULE19: output faults clear only at next enabling of the outputs.
// RULE20: actuator leaving active zone disables outputs at once.
// RULE21: red burst count names cause: 1 A, 2 B, 3 cross, 4 temp, 5 actuator.
`timescale 1ns/1ns
`default_nettype none
module ssdiag_core
  import ssdiag_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic SERIAL_MODE_I,
  input wire logic SAFETY_INPUT_A_I,
  input wire logic SAFETY_INPUT_B_I,
  input wire logic ACT_PRESENT_I,
  input wire logic ACT_MARGINAL_I,
  input wire logic TEACH_MODE_I,
  input wire logic TAMPER_START_I,
  input wire logic FAULT_OUT_A_I,
  input wire logic FAULT_OUT_B_I,
  input wire logic FAULT_CROSS_I,
  input wire logic FAULT_TEMP_I,
  input wire logic FAULT_ACTUATOR_I,
  input wire logic FAULT_INTERNAL_I,
  input wire logic LINK_OK_I,
  input wire logic [7:0] REQUEST_BYTE_I,
  input wire logic REQUEST_VALID_I,
  output logic SAFETY_OUTPUT_A_O,
  output logic SAFETY_OUTPUT_B_O,
  output logic DIAG_OUT_O,
  output logic SERIAL_DIAG_LINE_O,
  output logic [7:0] RESPONSE_BYTE_O,
  output logic LED_GREEN_O,
  output logic LED_RED_O,
  output logic LED_YELLOW_O
);
  localparam int unsigned NSYNC = 13;

  // sensing inputs in the synchronised vector
  localparam int unsigned IX_IN_A = 0;
  localparam int unsigned IX_IN_B = 1;
  localparam int unsigned IX_ACT = 2;
  localparam int unsigned IX_MARG = 3;
  localparam int unsigned IX_TEACH = 4;
  localparam int unsigned IX_TAMPER = 5;
  // fault causes and link state in the synchronised vector
  localparam int unsigned IX_FLT_A = 6;
  localparam int unsigned IX_FLT_B = 7;
  localparam int unsigned IX_CROSS = 8;
  localparam int unsigned IX_TEMP = 9;
  localparam int unsigned IX_ACT_FLT = 10;
  localparam int unsigned IX_INT = 11;
  localparam int unsigned IX_LINK = 12;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] stable;
    logic [HALF_W-1:0] half_cnt;
    logic blink;
    logic sec_tick;
    logic [SEC_W-1:0] warn_sec;
    logic warn_expired;
    logic [SEC_W-1:0] tamper_sec;
    logic tamper_active;
    ssdiag_mode_e mode;
    logic out_fault_latched;
    logic [2:0] err_cause;
    logic guard_opened;
    logic req_bit7_prev;
    logic [BURST_W-1:0] burst_pos;
    logic outputs_on;
    logic diag;
    logic led_g;
    logic led_r;
    logic led_y;
    logic [7:0] rsp;
  } ssdiag_state_s;

  ssdiag_state_s st_reg;
  ssdiag_state_s st_next;

  function automatic logic [2:0] cause_code(input logic [NSYNC-1:0] v);
    if (v[IX_FLT_A]) cause_code = BURST_OUT_A;
    else if (v[IX_FLT_B]) cause_code = BURST_OUT_B;
    else if (v[IX_CROSS]) cause_code = BURST_CROSS;
    else if (v[IX_TEMP]) cause_code = BURST_TEMP;
    else if (v[IX_ACT_FLT]) cause_code = BURST_ACTUATOR;
    else cause_code = BURST_NONE;
  endfunction

  function automatic logic [2:0] err_code(input logic [NSYNC-1:0] v);
    if (v[IX_ACT_FLT]) err_code = BURST_ACTUATOR;
    else err_code = BURST_NONE;
  endfunction

  function automatic logic is_mode(input ssdiag_mode_e m, input ssdiag_mode_e want);
    is_mode = (m == want);
  endfunction

  // response byte layout; bits 2 and 3 stay clear
  function automatic logic [7:0] rsp_byte(input logic on, input logic act, input logic live,
                                          input logic hyst, input logic warn, input logic err);
    rsp_byte = '0;
    rsp_byte[RSP_OUT_ON] = on; // RULE16
    rsp_byte[RSP_ACT_ID] = act;
    rsp_byte[RSP_INPUTS] = live;
    rsp_byte[RSP_HYST] = hyst;
    rsp_byte[RSP_WARN] = warn; // RULE17
    rsp_byte[RSP_ERROR] = err;
  endfunction

  // one bit per asynchronous input
  logic [NSYNC-1:0] raw_in;
  assign raw_in[IX_IN_A] = SAFETY_INPUT_A_I;
  assign raw_in[IX_IN_B] = SAFETY_INPUT_B_I;
  assign raw_in[IX_ACT] = ACT_PRESENT_I;
  assign raw_in[IX_MARG] = ACT_MARGINAL_I;
  assign raw_in[IX_TEACH] = TEACH_MODE_I;
  assign raw_in[IX_TAMPER] = TAMPER_START_I;
  assign raw_in[IX_FLT_A] = FAULT_OUT_A_I;
  assign raw_in[IX_FLT_B] = FAULT_OUT_B_I;
  assign raw_in[IX_CROSS] = FAULT_CROSS_I;
  assign raw_in[IX_TEMP] = FAULT_TEMP_I;
  assign raw_in[IX_ACT_FLT] = FAULT_ACTUATOR_I;
  assign raw_in[IX_INT] = FAULT_INTERNAL_I;
  assign raw_in[IX_LINK] = LINK_OK_I;

  logic inputs_live;
  logic act_present;
  logic act_marginal;
  logic teaching;
  logic tamper_start;
  logic warn_cause;
  logic err_now;
  logic link_ok;
  logic req_fall;
  logic burst_red;
  logic out_fault_now;
  logic outputs_blocked;

  always_comb begin
    st_next = st_reg;
    inputs_live = st_reg.stable[IX_IN_A] & st_reg.stable[IX_IN_B];
    act_present = st_reg.stable[IX_ACT];
    act_marginal = st_reg.stable[IX_MARG] & act_present;
    teaching = st_reg.stable[IX_TEACH];
    tamper_start = st_reg.stable[IX_TAMPER];
    out_fault_now = st_reg.stable[IX_FLT_A] | st_reg.stable[IX_FLT_B] | st_reg.stable[IX_CROSS];
    warn_cause = out_fault_now | st_reg.stable[IX_TEMP];
    err_now = st_reg.stable[IX_INT] | st_reg.stable[IX_ACT_FLT];
    link_ok = st_reg.stable[IX_LINK];
    outputs_blocked = !act_present || teaching || st_reg.tamper_active || !inputs_live
                      || is_mode(st_reg.mode, SSDIAG_ERROR);
    req_fall = SERIAL_MODE_I & REQUEST_VALID_I & st_reg.req_bit7_prev
               & ~REQUEST_BYTE_I[REQ_RESET]; // RULE18

    // three-stage synchroniser, change taken when stages two and three agree
    st_next.s1 = raw_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < NSYNC; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.stable[i] = st_reg.s3[i];
      end
    end

    // 1 Hz blink and one-second tick
    st_next.sec_tick = 1'b0;
    if (st_reg.half_cnt == HALF_W'(HALF_BLINK_CYC - 1)) begin
      st_next.half_cnt = '0;
      st_next.blink = ~st_reg.blink;
      st_next.sec_tick = st_reg.blink;
      if (st_reg.blink) begin
        st_next.burst_pos = st_reg.burst_pos + BURST_W'(1);
        if (st_reg.burst_pos == BURST_W'(st_reg.err_cause) + BURST_W'(BURST_GAP - 1)) begin
          st_next.burst_pos = '0;
        end
      end
    end else begin
      st_next.half_cnt = st_reg.half_cnt + HALF_W'(1);
    end

    if (REQUEST_VALID_I) begin
      st_next.req_bit7_prev = REQUEST_BYTE_I[REQ_RESET]; // RULE14
    end
    if (!act_present) begin
      st_next.guard_opened = 1'b1;
    end

    // tamper protection timer
    if (tamper_start) begin
      st_next.tamper_active = 1'b1;
      st_next.tamper_sec = '0;
    end else if (st_reg.tamper_active && st_reg.sec_tick) begin
      if (st_reg.tamper_sec == SEC_W'(TAMPER_TIME_SEC - 1)) begin
        st_next.tamper_active = 1'b0; // RULE8
      end else begin
        st_next.tamper_sec = st_reg.tamper_sec + SEC_W'(1);
      end
    end

    // an open guard at error entry already counts as opened
    case (st_reg.mode)
      SSDIAG_RUN: begin
        if (err_now) begin
          st_next.mode = SSDIAG_ERROR; // RULE1
          st_next.err_cause = err_code(st_reg.stable);
          st_next.guard_opened = !act_present;
        end else if (warn_cause) begin
          st_next.mode = SSDIAG_WARN; // RULE2
          st_next.err_cause = cause_code(st_reg.stable);
          st_next.warn_sec = '0;
        end
      end
      SSDIAG_WARN: begin
        if (err_now) begin
          st_next.mode = SSDIAG_ERROR;
          st_next.err_cause = err_code(st_reg.stable);
          st_next.guard_opened = !act_present;
        end else if (!warn_cause && !st_reg.warn_expired) begin
          st_next.mode = SSDIAG_RUN; // RULE3
        end else if (st_reg.sec_tick && !st_reg.warn_expired) begin
          if (st_reg.warn_sec == SEC_W'(WARN_TIMEOUT_SEC - 1)) begin
            st_next.warn_expired = 1'b1; // RULE4
            st_next.mode = SSDIAG_ERROR;
            st_next.guard_opened = !act_present;
          end else begin
            st_next.warn_sec = st_reg.warn_sec + SEC_W'(1);
          end
        end
      end
      SSDIAG_ERROR: begin
        // conventional, or serial with input A live: cause gone then guard opened and closed again
        if (!err_now && !warn_cause && st_reg.guard_opened && act_present
            && (!SERIAL_MODE_I || st_reg.stable[IX_IN_A])) begin
          st_next.mode = SSDIAG_RUN; // RULE1
          st_next.warn_expired = 1'b0;
        end else if (SERIAL_MODE_I && !err_now && !warn_cause
                     && (req_fall || st_reg.guard_opened)) begin
          st_next.mode = SSDIAG_RUN; // RULE18
          st_next.warn_expired = 1'b0;
        end
      end
      default: st_next.mode = SSDIAG_RUN;
    endcase

    // safety output enabling
    if (SERIAL_MODE_I && !link_ok) begin
      st_next.outputs_on = st_reg.outputs_on; // RULE15
    end else if (outputs_blocked) begin
      st_next.outputs_on = 1'b0; // RULE20
    end else begin
      st_next.outputs_on = 1'b1;
      if (!st_reg.outputs_on) begin
        st_next.out_fault_latched = 1'b0; // RULE19
      end
    end

    // output faults stay until the next enabling; a new fault wins over the clear
    if (out_fault_now) begin
      st_next.out_fault_latched = 1'b1;
    end

    // burst pattern: on while pulse number within cause, high half of blink
    burst_red = (st_reg.burst_pos < BURST_W'(st_reg.err_cause)) & st_reg.blink; // RULE21

    // LED and diagnostic output table
    st_next.led_g = 1'b0;
    st_next.led_r = 1'b0;
    st_next.led_y = 1'b0;
    st_next.diag = 1'b0;
    if (teaching) begin
      st_next.led_r = 1'b1; // RULE7
      st_next.led_y = st_reg.blink;
    end else if (st_reg.tamper_active) begin
      st_next.led_g = st_reg.blink; // RULE8
    end else if (!is_mode(st_reg.mode, SSDIAG_RUN)) begin
      st_next.led_r = (st_reg.err_cause == BURST_NONE) ? st_reg.blink : burst_red; // RULE2
    end else if (!inputs_live) begin
      st_next.led_g = st_reg.blink; // RULE9
      st_next.led_y = act_present; // RULE10
      st_next.diag = act_present;
    end else if (act_marginal) begin
      st_next.led_y = st_reg.blink; // RULE6
      st_next.diag = st_reg.blink;
    end else if (act_present) begin
      st_next.led_y = 1'b1; // RULE5
      st_next.diag = 1'b1;
    end else begin
      st_next.led_g = 1'b1;
    end

    // response byte, refreshed every cycle
    // while the outputs are off, an output fault not yet confirmed cleared reads as a warning
    st_next.rsp = rsp_byte(st_reg.outputs_on, act_present, inputs_live, act_marginal,
                           is_mode(st_reg.mode, SSDIAG_WARN) | warn_cause
                           | (st_reg.out_fault_latched & ~st_reg.outputs_on), // RULE19
                           is_mode(st_reg.mode, SSDIAG_ERROR));
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SAFETY_OUTPUT_A_O = st_reg.outputs_on;
  assign SAFETY_OUTPUT_B_O = st_reg.outputs_on;
  assign DIAG_OUT_O = SERIAL_MODE_I ? 1'b0 : st_reg.diag; // RULE11
  assign SERIAL_DIAG_LINE_O = SERIAL_MODE_I ? st_reg.diag : 1'b0;
  assign RESPONSE_BYTE_O = st_reg.rsp; // RULE13
  assign LED_GREEN_O = st_reg.led_g;
  assign LED_RED_O = st_reg.led_r;
  assign LED_YELLOW_O = st_reg.led_y;
endmodule
`default_nettype wire

//--- hw/ssdiag_pkg.sv
/*
  ssdiag_pkg: constants and types for the safety sensor status and fault logic.
  Assumes a single 25 MHz core clock; long times are derived from it here.
*/
package ssdiag_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned WARN_TIMEOUT_MIN = 30;
  localparam int unsigned TAMPER_TIME_MIN = 10;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned HALF_BLINK_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned WARN_TIMEOUT_SEC = WARN_TIMEOUT_MIN * SEC_PER_MIN;
  localparam int unsigned TAMPER_TIME_SEC = TAMPER_TIME_MIN * SEC_PER_MIN;
  localparam int unsigned MAX_CHAIN_LEN = 31;
  localparam int unsigned CHAIN_IDX_W = 5;
  localparam int unsigned SEC_W = 12;
  localparam int unsigned HALF_W = 24;
  localparam int unsigned BURST_GAP = 3;
  localparam int unsigned BURST_W = 3;

  // response byte bit positions and request reset bit
  localparam int unsigned RSP_OUT_ON = 0;
  localparam int unsigned RSP_ACT_ID = 1;
  localparam int unsigned RSP_INPUTS = 4;
  localparam int unsigned RSP_HYST = 5;
  localparam int unsigned RSP_WARN = 6;
  localparam int unsigned RSP_ERROR = 7;
  localparam int unsigned REQ_RESET = 7;

  // red burst counts per error cause
  localparam logic [2:0] BURST_OUT_A = 3'h1;
  localparam logic [2:0] BURST_OUT_B = 3'h2;
  localparam logic [2:0] BURST_CROSS = 3'h3;
  localparam logic [2:0] BURST_TEMP = 3'h4;
  localparam logic [2:0] BURST_ACTUATOR = 3'h5;
  localparam logic [2:0] BURST_NONE = 3'h0;

  typedef enum logic [1:0] {
    SSDIAG_RUN,
    SSDIAG_WARN,
    SSDIAG_ERROR
  } ssdiag_mode_e;
endpackage

//--- verif/ssdiag_core_asserts.sv
/*
  ssdiag_chk: port checker for ssdiag_core, bound below.
  Assumes the single core clock and its async active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ssdiag_chk (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic SERIAL_MODE_I,
  input wire logic SAFETY_INPUT_A_I,
  input wire logic SAFETY_INPUT_B_I,
  input wire logic ACT_PRESENT_I,
  input wire logic TEACH_MODE_I,
  input wire logic FAULT_INTERNAL_I,
  input wire logic LINK_OK_I,
  input wire logic SAFETY_OUTPUT_A_O,
  input wire logic SAFETY_OUTPUT_B_O,
  input wire logic DIAG_OUT_O,
  input wire logic SERIAL_DIAG_LINE_O,
  input wire logic [7:0] RESPONSE_BYTE_O,
  input wire logic LED_RED_O,
  input wire logic LED_GREEN_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic hold_ok;
  // a dead gateway link freezes the outputs
  assign hold_ok = LINK_OK_I || !SERIAL_MODE_I;
  sequence s_gone; (!ACT_PRESENT_I && hold_ok)[*7]; endsequence
  sequence s_int; (FAULT_INTERNAL_I && hold_ok)[*7]; endsequence
  sequence s_teach; (TEACH_MODE_I && hold_ok)[*7]; endsequence
  sequence s_dead; (!SAFETY_INPUT_A_I && hold_ok)[*7]; endsequence
  property p_gone; s_gone |-> !SAFETY_OUTPUT_A_O && !SAFETY_OUTPUT_B_O; endproperty
  property p_int; s_int |-> !SAFETY_OUTPUT_A_O && !DIAG_OUT_O && RESPONSE_BYTE_O[7]; endproperty
  property p_teach; s_teach |-> LED_RED_O && !LED_GREEN_O && !SAFETY_OUTPUT_A_O; endproperty
  property p_dead; s_dead |-> !RESPONSE_BYTE_O[4] && !SAFETY_OUTPUT_A_O; endproperty
  property p_live; (SAFETY_INPUT_A_I && SAFETY_INPUT_B_I)[*7] |-> RESPONSE_BYTE_O[4]; endproperty
  property p_pair; SAFETY_OUTPUT_A_O == SAFETY_OUTPUT_B_O; endproperty
  property p_bit0; $rose(SAFETY_OUTPUT_A_O) |-> ##[0:2] RESPONSE_BYTE_O[0]; endproperty
  property p_serial; SERIAL_MODE_I[*3] |-> !DIAG_OUT_O; endproperty
  property p_rsv; RESPONSE_BYTE_O[3:2] == 2'h0; endproperty
  property p_freeze; (SERIAL_MODE_I && !LINK_OK_I)[*7] |-> $stable(SAFETY_OUTPUT_A_O); endproperty
  a_gone: assert property (p_gone) else $error("outputs on without actuator");
  a_int: assert property (p_int) else $error("internal error not shown");
  a_teach: assert property (p_teach) else $error("teach pattern wrong");
  a_dead: assert property (p_dead) else $error("missing input not shown");
  a_live: assert property (p_live) else $error("live inputs bit clear");
  a_pair: assert property (p_pair) else $error("safety outputs differ");
  a_bit0: assert property (p_bit0) else $error("output on bit late");
  a_serial: assert property (p_serial) else $error("diag out in serial mode");
  a_rsv: assert property (p_rsv) else $error("unused response bits set");
  a_freeze: assert property (p_freeze) else $error("outputs moved on dead link");
endmodule
bind ssdiag_core ssdiag_chk i_chk (.CORE_CLK_I, .RSTN_I, .SERIAL_MODE_I, .SAFETY_INPUT_A_I,
  .SAFETY_INPUT_B_I, .ACT_PRESENT_I, .TEACH_MODE_I, .FAULT_INTERNAL_I, .LINK_OK_I,
  .SAFETY_OUTPUT_A_O, .SAFETY_OUTPUT_B_O, .DIAG_OUT_O, .SERIAL_DIAG_LINE_O,
  .RESPONSE_BYTE_O, .LED_RED_O, .LED_GREEN_O);
`default_nettype wire

//--- verif/ssdiag_gw_model.sv
/*
  ssdiag_gw_model: gateway side, sends a request byte every fourth cycle.
  Assumes the core clock; bit 7 carries the error reset request.
*/
`timescale 1ns/1ns
`default_nettype none
module ssdiag_gw_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic link_up_i,
  input wire logic reset_req_i,
  output logic [7:0] req_byte_o,
  output logic req_valid_o,
  output logic link_ok_o
);
  logic [1:0] slot;
  assign link_ok_o = link_up_i;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot <= 2'h0;
      req_valid_o <= 1'b0;
      req_byte_o <= 8'h00;
    end else begin
      slot <= slot + 2'h1;
      req_valid_o <= link_up_i && slot == 2'h3;
      if (link_up_i && slot == 2'h3) begin
        req_byte_o <= {reset_req_i, 7'h00};
      end else begin
        req_byte_o <= ~req_byte_o;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/ssdiag_core_tb.sv
/*
  ssdiag_core_tb: self-checking bench for ssdiag_core with a gateway model.
  Assumes the 25 MHz clock; inputs move 2 ns after each rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ssdiag_core_tb;
  logic clk = 0, rstn = 0, smode = 0, in_a = 0, in_b = 0, act = 0, marg = 0;
  logic teach = 0, tamper = 0, link_up = 1, rreq = 0, f_act = 0, f_int = 0;
  logic [3:0] warn = 0;
  logic [7:0] req_b, rsp;
  logic req_v, link_ok, out_a, out_b, diag, sline, g, r, y;
  int fails = 0, cmp_count = 0, seed = 34572;
  always #20 clk = ~clk;
  ssdiag_gw_model i_gw (.clk_i(clk), .rstn_i(rstn), .link_up_i(link_up), .reset_req_i(rreq),
    .req_byte_o(req_b), .req_valid_o(req_v), .link_ok_o(link_ok));
  ssdiag_core i_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .SERIAL_MODE_I(smode),
    .SAFETY_INPUT_A_I(in_a), .SAFETY_INPUT_B_I(in_b), .ACT_PRESENT_I(act),
    .ACT_MARGINAL_I(marg), .TEACH_MODE_I(teach), .TAMPER_START_I(tamper),
    .FAULT_OUT_A_I(warn[0]), .FAULT_OUT_B_I(warn[1]), .FAULT_CROSS_I(warn[2]),
    .FAULT_TEMP_I(warn[3]), .FAULT_ACTUATOR_I(f_act), .FAULT_INTERNAL_I(f_int),
    .LINK_OK_I(link_ok), .REQUEST_BYTE_I(req_b), .REQUEST_VALID_I(req_v),
    .SAFETY_OUTPUT_A_O(out_a), .SAFETY_OUTPUT_B_O(out_b), .DIAG_OUT_O(diag),
    .SERIAL_DIAG_LINE_O(sline), .RESPONSE_BYTE_O(rsp), .LED_GREEN_O(g), .LED_RED_O(r),
    .LED_YELLOW_O(y));
  task automatic close_out;
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (10) @(posedge clk);
    #2;
  endtask
  task automatic do_reset(input logic sm);
    rstn = 0;
    smode = sm;
    repeat (6) @(posedge clk);
    #2 rstn = 1;
  endtask
  // response byte, diag, out a, out b, yellow
  function automatic logic [11:0] exp_obs(input logic a, input logic b, input logic c);
    return {3'h0, b & c, 2'h0, a, a & b & c, a, a & b & c, a & b & c, a};
  endfunction
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    do_reset(0);
    chk({rsp, diag, out_a, out_b, y}, 12'h000);
    {in_a, in_b, act} = 3'h7;
    settle();
    chk({rsp, diag, out_a, out_b, y}, exp_obs(1, 1, 1));
    marg = 1;
    settle();
    chk({rsp, out_a, out_b}, {8'h33, 2'h3});
    marg = 0;
    for (int i = 0; i < 4; i++) begin
      warn[i] = 1;
      settle();
      chk({rsp, diag, out_a, out_b}, {8'h53, 3'h3});
      warn = 0;
      settle();
      chk({rsp, diag, out_a, out_b, y}, exp_obs(1, 1, 1));
    end
    for (int j = 1; j < 3; j++) begin
      {f_act, f_int} = 2'(j);
      settle();
      chk({rsp[7], rsp[0], diag, out_a, out_b}, 5'h10);
      {f_act, f_int} = 2'h0;
      settle();
      chk(out_a, 0);
      act = 0;
      settle();
      chk({out_a, out_b, rsp[1], rsp[6]}, {3'h0, j == 1});
      act = 1;
      settle();
      chk({rsp, diag, out_a, out_b, y}, exp_obs(1, 1, 1));
    end
    repeat (10) begin
      {act, in_a, in_b} = 3'($random(seed));
      settle();
      chk({rsp, diag, out_a, out_b, y}, exp_obs(act, in_a, in_b));
    end
    {in_a, in_b, act} = 3'h7;
    do_reset(1);
    settle();
    chk({rsp, sline, diag, out_a, out_b}, {8'h13, 4'hb});
    f_int = 1;
    settle();
    f_int = 0;
    settle();
    chk(out_a, 0);
    rreq = 1;
    settle();
    rreq = 0;
    settle();
    chk({rsp, out_a}, {8'h13, 1'b1});
    link_up = 0;
    settle();
    act = 0;
    settle();
    chk(out_a, 1);
    link_up = 1;
    settle();
    chk(out_a, 0);
    act = 1;
    teach = 1;
    settle();
    chk({out_a, out_b, sline, r, g}, 5'h02);
    teach = 0;
    tamper = 1;
    repeat (3) @(posedge clk);
    #2 tamper = 0;
    settle();
    chk({out_a, out_b, sline, r, y}, 5'h00);
    close_out();
  end
endmodule
`default_nettype wire
